// ### inc/spam_defs.svh
/*
 constants of the sensor period and amplitude monitor: register word offsets,
 field positions, reset values, accepted ranges and timing counts.
 assumes a 250 MHz core clock and 16-bit register word addresses.
*/
`ifndef SPAM_DEFS_SVH
`define SPAM_DEFS_SVH

// ==========================================================
// register word offsets
`define OFS_EXC 16'h4400
`define OFS_SETTING 16'h4402
`define OFS_LEFT 16'h4404
`define OFS_RIGHT 16'h4406
`define OFS_LOOP 16'h4408
`define OFS_CUR_RAW 16'h440a
`define OFS_CUR_MA 16'h440c
`define OFS_GAIN 16'h440e
`define OFS_DRV_STAB 16'h4410
`define OFS_AMP_STAB 16'h4412
`define OFS_LIM_LO 16'h6200
`define OFS_LIM_HI 16'h6202
`define OFS_BAND 16'h6204
`define OFS_THR 16'h6206
`define OFS_FLEN 16'h6208
`define OFS_SNB 16'h620a
`define OFS_SOFT_ERR 16'h401c
`define OFS_PRAW 16'h4200
`define OFS_PFILT 16'h4202
`define OFS_PSTAB 16'h4204

// ==========================================================
// soft error field positions
`define SE_PER_A 12
`define SE_PER_B 13
`define SE_SIC 14

// ==========================================================
// reset values and accepted write ranges
`define RST_LIM_LO 32'h0004c4b4
`define RST_LIM_HI 32'h002625a0
`define RST_BAND 32'h000186a0
`define RST_THR 32'h0000000a
`define RST_FLEN 32'h00000050
`define RST_SNB 32'h00001388
`define LIM_LO_MIN 32'h0001e848
`define LIM_HI_MIN 32'h0004c4b4
`define LIM_MAX 32'h002625a0
`define THR_MAX 32'h00000064
`define FLEN_MAX 32'h000000c8
`define SNB_MAX 32'h000186a0
`define PCT_FULL 7'h64
`define GAIN_FULL 32'h00000fff

// ==========================================================
// timing
`define CLK_PERIOD_PS 4000
`define TIMEBASE_NS 8
`define TIMEBASE_CYC ((`TIMEBASE_NS * 1000) / `CLK_PERIOD_PS)
`define TAU_MS 8000
`define TAU_SHIFT 13
`define STAB_TICK_CYC_DEF (((64'd1000000000 * `TAU_MS) / `CLK_PERIOD_PS) >> `TAU_SHIFT)
`define CUR_SHIFT_DEF 10

`endif

// ### inc/spam_pkg.sv
/*
 types of the sensor period and amplitude monitor.
 assumes spam_defs.svh is on the include path.
*/
package spam_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACCUM = 3'b001,
      ST_DIV = 3'b010,
      ST_CHECK = 3'b011
   } fsm_t;

   typedef enum logic [1:0] {
      JOB_PFILT = 2'b00,
      JOB_DRV = 2'b01,
      JOB_AMP = 2'b10,
      JOB_GAIN = 2'b11
   } job_t;

   // live values from the drive and pickup front end
   typedef struct packed {
      logic [11:0] exc;
      logic [11:0] setting;
      logic [11:0] left;
      logic [11:0] right;
      logic [11:0] loop;
      logic [14:0] cur_raw;
      logic [11:0] target;
   } meas_t;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic ack;
      logic err;
   } reg_rsp_t;

   typedef struct packed {
      logic [2:0] sync;
      logic lvl;
      logic armed;
      logic tb;
      logic [23:0] per_cnt;
      logic [1:0] edges;
      logic pend;
      logic [21:0] pend_raw;
      logic [21:0] raw;
      logic [21:0] filt;
      logic [21:0] pstab;
      logic [31:0] sum;
      logic [7:0] fill;
      logic [7:0] wp;
      fsm_t st;
      job_t job;
      logic [31:0] quo;
      logic [31:0] den;
      logic [31:0] rem;
      logic [4:0] cnt;
      logic [6:0] drv_pct;
      logic [6:0] amp_pct;
      logic [6:0] gain_pct;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [31:0] band;
      logic [31:0] thr;
      logic [31:0] flen;
      logic [31:0] snb;
      logic [6:0] err_cnt;
      logic se_per;
      logic se_sic;
      logic [31:0] stick;
      logic stab_due;
      logic [11:0] prev_loop;
      logic [31:0] dfilt;
      logic [31:0] afilt;
      logic [31:0] rdata;
      logic ack;
      logic err;
   } state_t;

endpackage

// ### src/period_hist_mem.sv
/*
 history of raw period samples for the running average, 256 words.
 assumes one write and one read port on the same clock; read data registered.
*/
`timescale 1ns/1ps
`default_nettype none

module period_hist_mem (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [7:0] i_waddr,
   input wire logic [21:0] i_wdata,
   input wire logic [7:0] i_raddr,
   output logic [21:0] o_rdata
);

   logic [21:0] mem [256];

   // contents need no reset: only words below the fill level are ever used
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule

`default_nettype wire

// ### src/sensor_period_amplitude_monitor.sv
/*
 sensor period and amplitude monitor: measures the oscillation period from the
 pickup zero-crossing pin, filters and checks it, derives stability figures and
 serves the register map through a word-addressed request port.
 assumes the front end delivers the amplitude values in i_meas on i_clk.
*/
// Function
// - drive coil excitation readable, 0 to 4095, read only.
// - feedback drive output setting readable, 0 to 4095.
// - left and right pickup peak levels readable, each 0 to 4095.
// - drive loop output readable, plus matching gain percentage.
// - raw drive current 0 to 32767 and float milliampere value readable.
// - drive stability: 100 minus filtered output change percent, tau 8 s.
// - amplitude stability: 100 minus filtered deviation from target, tau 8 s.
// - low period limit in 8 ns units, 125000 to 2500000, default 312500.
// - high period limit in 8 ns units, 312500 to 2500000, default 2500000.
// - period outside the two limits sets soft error bits 12 and 13.
// - raw minus filtered period above noise band sets bits 12 and 13.
// - integrity warning after threshold consecutive period errors, 1 to 100.
// - error counter evaluated once every four sensor periods.
// - filter length 1 to 200 samples, default 80.
// - filter takes raw samples every four periods, gives filtered period.
// - smart filter noise band stored, 0 to 100000, default 5000, unused.
// - raw period in 8 ns units, mean of last four periods.
// - period stability is absolute raw minus filtered period.
`timescale 1ns/1ps
`default_nettype none
`include "spam_defs.svh"

module sensor_period_amplitude_monitor
   import spam_pkg::*;
#(
   parameter int unsigned STAB_TICK_CYC = 32'(`STAB_TICK_CYC_DEF),
   parameter logic [7:0] CUR_SHIFT = 8'(`CUR_SHIFT_DEF)
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pickup_zc,
   input wire meas_t i_meas,
   input wire reg_req_t i_req,
   output reg_rsp_t o_rsp
);

   state_t s;
   state_t n;
   logic mem_we;
   logic [7:0] mem_raddr;
   logic [21:0] mem_rdata;

   // ==========================================================
   // helpers
   function automatic logic [31:0] to_float(input logic [31:0] v, input logic [7:0] sub);
      logic [4:0] p;
      logic [31:0] m;
      p = 5'h0;
      for (int i = 0; i < 32; i++) begin
         if (v[i]) begin
            p = i[4:0];
         end
      end
      m = v << (5'h1f - p);
      if (v == 32'h0) begin
         return 32'h0;
      end
      return {1'b0, 8'(8'h7f + {3'h0, p} - sub), m[30:8]};
   endfunction

   function automatic logic [11:0] absdiff12(input logic [11:0] a, input logic [11:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   // ==========================================================
   // history memory
   period_hist_mem u_hist (
      .i_clk(i_clk),
      .i_we(mem_we),
      .i_waddr(s.wp),
      .i_wdata(s.pend_raw),
      .i_raddr(mem_raddr),
      .o_rdata(mem_rdata)
   );

   // ==========================================================
   // next state
   always_comb begin
      logic rise;
      logic [21:0] quart;
      logic [21:0] old;
      logic [31:0] nsum;
      logic [7:0] nfill;
      logic [32:0] rem_sh;
      logic [21:0] pst;
      logic [12:0] avg;
      logic [11:0] adev;
      logic [6:0] pct;
      logic perr;
      rise = 1'b0;
      quart = s.per_cnt[23:2];
      old = 22'h0;
      nsum = 32'h0;
      nfill = 8'h0;
      rem_sh = 33'h0;
      pst = 22'h0;
      avg = 13'h0;
      adev = 12'h0;
      pct = 7'h0;
      perr = 1'b0;
      n = s;
      mem_we = 1'b0;
      mem_raddr = s.wp - s.flen[7:0];
      n.ack = 1'b0;
      n.err = 1'b0;

      // filtering of drive change and amplitude deviation, shared time constant
      if (s.stick >= STAB_TICK_CYC - 1) begin
         n.stick = 32'h0;
         n.stab_due = 1'b1;
         n.prev_loop = i_meas.loop;
         n.dfilt = s.dfilt + {20'h0, absdiff12(i_meas.loop, s.prev_loop)} - (s.dfilt >> `TAU_SHIFT);
         avg = 13'(({1'b0, i_meas.left} + {1'b0, i_meas.right}) >> 1);
         adev = (avg[11:0] > i_meas.target) ? avg[11:0] - i_meas.target : i_meas.target - avg[11:0];
         n.afilt = s.afilt + {20'h0, adev} - (s.afilt >> `TAU_SHIFT);
      end else begin
         n.stick = s.stick + 32'h1;
      end

      // sequencer: running average, serial divide, checks
      unique case (s.st)
         ST_IDLE: begin
            if (s.pend) begin
               n.pend = 1'b0;
               n.st = ST_ACCUM;
            end else if (s.stab_due) begin
               n.stab_due = 1'b0;
               n.quo = 32'(s.dfilt * 32'd100);
               n.den = {7'h0, s.prev_loop, 13'h0};
               n.rem = 32'h0;
               n.cnt = 5'h0;
               n.job = JOB_DRV;
               n.st = ST_DIV;
            end
         end
         ST_ACCUM: begin
            // the oldest of the last flen samples drops out once the window is full
            old = (s.fill >= s.flen[7:0]) ? mem_rdata : 22'h0;
            nsum = s.sum + {10'h0, s.pend_raw} - {10'h0, old};
            nfill = (s.fill >= s.flen[7:0]) ? s.flen[7:0] : s.fill + 8'h1;
            mem_we = 1'b1;
            n.wp = s.wp + 8'h1;
            n.raw = s.pend_raw;
            n.sum = nsum;
            n.fill = nfill;
            n.quo = nsum;
            n.den = {24'h0, nfill};
            n.rem = 32'h0;
            n.cnt = 5'h0;
            n.job = JOB_PFILT;
            n.st = ST_DIV;
         end
         ST_DIV: begin
            rem_sh = {s.rem, s.quo[31]};
            if (rem_sh >= {1'b0, s.den}) begin
               n.rem = 32'(rem_sh - {1'b0, s.den});
               n.quo = {s.quo[30:0], 1'b1};
            end else begin
               n.rem = rem_sh[31:0];
               n.quo = {s.quo[30:0], 1'b0};
            end
            n.cnt = s.cnt + 5'h1;
            if (s.cnt == 5'h1f) begin
               n.st = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // a zero divisor means nothing to compare against, so report no deviation
            pct = (s.den == 32'h0) ? 7'h0 : ((s.quo > 32'd100) ? `PCT_FULL : s.quo[6:0]);
            n.st = ST_IDLE;
            unique case (s.job)
               JOB_PFILT: begin
                  n.filt = s.quo[21:0];
                  pst = (s.raw > s.quo[21:0]) ? s.raw - s.quo[21:0] : s.quo[21:0] - s.raw;
                  n.pstab = pst;
                  perr = ({10'h0, s.raw} < s.lo) || ({10'h0, s.raw} > s.hi);
                  perr = perr || ({10'h0, pst} > s.band);
                  n.se_per = perr;
                  // evaluated once per sample, i.e. every fourth sensor period
                  n.err_cnt = perr ? ((s.err_cnt == 7'h7f) ? s.err_cnt : s.err_cnt + 7'h1) : 7'h0;
                  n.se_sic = perr && ({25'h0, s.err_cnt} + 32'h1 >= s.thr);
               end
               JOB_DRV: begin
                  n.drv_pct = pct;
                  n.quo = 32'(s.afilt * 32'd100);
                  n.den = {7'h0, i_meas.target, 13'h0};
                  n.rem = 32'h0;
                  n.cnt = 5'h0;
                  n.job = JOB_AMP;
                  n.st = ST_DIV;
               end
               JOB_AMP: begin
                  n.amp_pct = pct;
                  n.quo = 32'({20'h0, i_meas.loop} * 32'd100);
                  n.den = `GAIN_FULL;
                  n.rem = 32'h0;
                  n.cnt = 5'h0;
                  n.job = JOB_GAIN;
                  n.st = ST_DIV;
               end
               JOB_GAIN: begin
                  n.gain_pct = pct;
               end
            endcase
         end
      endcase

      // pin synchroniser and period counting in 8 ns units
      n.sync = {s.sync[1:0], i_pickup_zc};
      if (s.sync[2] == s.sync[1]) begin
         n.lvl = s.sync[2];
      end
      rise = n.lvl & ~s.lvl;
      n.tb = ~s.tb;
      if (s.tb && s.per_cnt != 24'hffffff) begin
         n.per_cnt = s.per_cnt + 24'h1;
      end
      // set wins over the sequencer's clear of the pending flag
      if (rise) begin
         if (!s.armed) begin
            n.armed = 1'b1;
            n.per_cnt = 24'h0;
            n.edges = 2'h0;
         end else if (s.edges == 2'h3) begin
            n.pend = 1'b1;
            n.pend_raw = quart;
            n.per_cnt = 24'h0;
            n.edges = 2'h0;
         end else begin
            n.edges = s.edges + 2'h1;
         end
      end else if (s.armed && {10'h0, quart} > s.hi) begin
         // lost oscillation still yields an out-of-range sample
         n.pend = 1'b1;
         n.pend_raw = quart;
         n.per_cnt = 24'h0;
         n.edges = 2'h0;
         n.armed = 1'b0;
      end

      // register port
      if (i_req.wr || i_req.rd) begin
         n.ack = 1'b1;
      end
      if (i_req.wr) begin
         unique case (i_req.addr)
            `OFS_LIM_LO: begin
               if (i_req.wdata >= `LIM_LO_MIN && i_req.wdata <= `LIM_MAX) n.lo = i_req.wdata;
               else n.err = 1'b1;
            end
            `OFS_LIM_HI: begin
               if (i_req.wdata >= `LIM_HI_MIN && i_req.wdata <= `LIM_MAX) n.hi = i_req.wdata;
               else n.err = 1'b1;
            end
            `OFS_BAND: n.band = i_req.wdata;
            `OFS_THR: begin
               if (i_req.wdata >= 32'h1 && i_req.wdata <= `THR_MAX) n.thr = i_req.wdata;
               else n.err = 1'b1;
            end
            `OFS_FLEN: begin
               if (i_req.wdata >= 32'h1 && i_req.wdata <= `FLEN_MAX) begin
                  // a new length restarts the average instead of mixing windows
                  n.flen = i_req.wdata;
                  n.fill = 8'h0;
                  n.sum = 32'h0;
               end else begin
                  n.err = 1'b1;
               end
            end
            `OFS_SNB: begin
               if (i_req.wdata <= `SNB_MAX) n.snb = i_req.wdata;
               else n.err = 1'b1;
            end
            default: n.err = 1'b1;
         endcase
      end
      if (i_req.rd) begin
         unique case (i_req.addr)
            `OFS_EXC: n.rdata = {20'h0, i_meas.exc};
            `OFS_SETTING: n.rdata = {20'h0, i_meas.setting};
            `OFS_LEFT: n.rdata = {20'h0, i_meas.left};
            `OFS_RIGHT: n.rdata = {20'h0, i_meas.right};
            `OFS_LOOP: n.rdata = {20'h0, i_meas.loop};
            `OFS_CUR_RAW: n.rdata = {17'h0, i_meas.cur_raw};
            `OFS_CUR_MA: n.rdata = to_float({17'h0, i_meas.cur_raw}, CUR_SHIFT);
            `OFS_GAIN: n.rdata = {25'h0, s.gain_pct};
            `OFS_DRV_STAB: n.rdata = to_float({25'h0, `PCT_FULL - s.drv_pct}, 8'h0);
            `OFS_AMP_STAB: n.rdata = to_float({25'h0, `PCT_FULL - s.amp_pct}, 8'h0);
            `OFS_LIM_LO: n.rdata = s.lo;
            `OFS_LIM_HI: n.rdata = s.hi;
            `OFS_BAND: n.rdata = s.band;
            `OFS_THR: n.rdata = s.thr;
            `OFS_FLEN: n.rdata = s.flen;
            `OFS_SNB: n.rdata = s.snb;
            `OFS_SOFT_ERR: begin
               n.rdata = 32'h0;
               n.rdata[`SE_PER_A] = s.se_per;
               n.rdata[`SE_PER_B] = s.se_per;
               n.rdata[`SE_SIC] = s.se_sic;
            end
            `OFS_PRAW: n.rdata = {10'h0, s.raw};
            `OFS_PFILT: n.rdata = {10'h0, s.filt};
            `OFS_PSTAB: n.rdata = {10'h0, s.pstab};
            default: begin
               n.rdata = 32'h0;
               n.err = 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.job <= JOB_PFILT;
         s.lo <= `RST_LIM_LO;
         s.hi <= `RST_LIM_HI;
         s.band <= `RST_BAND;
         s.thr <= `RST_THR;
         s.flen <= `RST_FLEN;
         s.snb <= `RST_SNB;
      end else begin
         s <= n;
      end
   end

   assign o_rsp = '{rdata: s.rdata, ack: s.ack, err: s.err};

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_sample_taken;
      s.st == ST_IDLE && s.pend ##1 s.st == ST_ACCUM;
   endsequence

   a_exc_read: assert property ((i_req.rd && i_req.addr == `OFS_EXC) |=>
      (o_rsp.ack && o_rsp.rdata == {20'h0, $past(i_meas.exc)})) else $error("excitation read wrong");
   a_left_read: assert property ((i_req.rd && i_req.addr == `OFS_LEFT) |=>
      (o_rsp.rdata == {20'h0, $past(i_meas.left)})) else $error("left pickup read wrong");
   a_lo_refused: assert property ((i_req.wr && i_req.addr == `OFS_LIM_LO && i_req.wdata < `LIM_LO_MIN)
      |=> (o_rsp.err && $stable(s.lo))) else $error("low limit accepted out of range");
   a_thr_refused: assert property ((i_req.wr && i_req.addr == `OFS_THR && i_req.wdata == 32'h0)
      |=> (o_rsp.err && $stable(s.thr))) else $error("zero threshold accepted");
   a_range_flag: assert property ((s.st == ST_CHECK && s.job == JOB_PFILT &&
      ({10'h0, s.raw} < s.lo || {10'h0, s.raw} > s.hi)) |=> s.se_per)
      else $error("out of range period not flagged");
   a_sic_cause: assert property (s.se_sic |-> ({25'h0, s.err_cnt} >= s.thr && s.se_per))
      else $error("integrity warning without enough errors");
   a_pstab_abs: assert property (s.st == ST_IDLE |->
      s.pstab == ((s.raw > s.filt) ? s.raw - s.filt : s.filt - s.raw)) else $error("period stability wrong");
   a_fill_bound: assert property (s.fill <= s.flen[7:0]) else $error("fill beyond length");
   a_sample_done: assert property (s_sample_taken |-> ##[33:34] (s.st == ST_CHECK && s.job == JOB_PFILT))
      else $error("filter update late");

endmodule

`default_nettype wire

// ### bench/sensor_coil_model.sv
/*
 pickup coil model: a zero-crossing square wave with a settable half period.
 assumes the bench gives the half period in clock cycles; the pin rests low when disabled.
*/
`timescale 1ns/1ps
`default_nettype none

module sensor_coil_model (
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic [15:0] i_half,
   output logic o_zc
);
   logic [15:0] cnt = 16'h0000;

   initial o_zc = 1'b0;

   // the half period is compared live, so a change lands on the phase already running
   always @(posedge i_clk) begin
      if (!i_en) begin
         o_zc <= 1'b0;
         cnt <= 16'h0000;
      end else if (cnt + 16'h0001 >= i_half) begin
         o_zc <= ~o_zc;
         cnt <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule

`default_nettype wire

// ### bench/testbench.sv
/*
 self-checking bench of the sensor period and amplitude monitor.
 assumes the register port answers one cycle after a one-cycle request pulse.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module testbench;
   import spam_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic en = 1'b0;
   logic zc;
   logic prev = 1'b0;
   logic [15:0] half = 16'h0064;
   meas_t meas = '{12'h0, 12'h0, 12'h100, 12'h100, 12'h0, 15'h0, 12'h100};
   reg_req_t req = '0;
   reg_rsp_t rsp;
   logic [31:0] rd;
   logic er;
   logic [31:0] dflt [6] = '{32'h4c4b4, 32'h2625a0, 32'h186a0, 32'ha, 32'h50, 32'h1388};
   logic [31:0] ex [8];
   logic [48:0] wt [13] = '{{16'h6200, 32'h1e847, 1'b1}, {16'h6200, 32'h1e848, 1'b0},
      {16'h6202, 32'h4c4b3, 1'b1}, {16'h6202, 32'h2625a1, 1'b1}, {16'h6202, 32'h4c4b4, 1'b0},
      {16'h6206, 32'h0, 1'b1}, {16'h6206, 32'h65, 1'b1}, {16'h6206, 32'h3, 1'b0},
      {16'h6208, 32'h0, 1'b1}, {16'h6208, 32'hc9, 1'b1}, {16'h6208, 32'h2, 1'b0},
      {16'h620a, 32'h186a1, 1'b1}, {16'h620a, 32'h0, 1'b0}};
   int fail_count = 0;
   int checks = 0;
   int edges = 0;
   int raws[$];
   int i, k, sum, raw, filt;

   sensor_coil_model i_coil (.i_clk(i_clk), .i_en(en), .i_half(half), .o_zc(zc));

   sensor_period_amplitude_monitor #(.STAB_TICK_CYC(4), .CUR_SHIFT(8'h0a)) i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_pickup_zc(zc), .i_meas(meas), .i_req(req), .o_rsp(rsp));

   always #2 i_clk = ~i_clk;

   always @(posedge i_clk) begin
      prev <= zc;
      if (zc && !prev) begin
         edges <= edges + 1;
      end
   end

   // ==========================================================
   // helpers
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a missing acknowledge turns err unknown, so the err compare after that access fails
   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge i_clk);
      #1;
      req = '{a, ~w, w, d};
      @(posedge i_clk);
      #1;
      req.rd = 1'b0;
      req.wr = 1'b0;
      rd = rsp.rdata;
      er = rsp.ack ? rsp.err : 1'bx;
   endtask

   task automatic wait_edges(input int n);
      int j;
      for (j = 0; j < 4000 && edges < n; j++) begin
         @(posedge i_clk);
      end
      if (edges < n) begin
         fail_count++;
         $display("[ERR] %0t no pickup edge", $time);
         end_sim();
      end
   endtask

   function automatic logic [31:0] flt(input int n, input int sh);
      int p;
      p = 0;
      if (n == 0) return 32'h0;
      while ((n >> (p + 1)) != 0) p++;
      return {1'b0, 8'(127 + p - sh), 23'((n << (23 - p)) & 32'h7fffff)};
   endfunction

   // period figures may differ by a tick or two from where the edges fall against the time base
   function automatic logic near(input logic [31:0] a, input int b);
      return (^a !== 1'bx) && (int'(a) - b <= 2) && (b - int'(a) <= 2);
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(86));
      repeat (2) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      for (i = 0; i < 6; i++) begin
         acc(0, 16'h6200 + 16'(2 * i), 0);
         `CHK({er, rd}, {1'b0, dflt[i]})
      end
      $display("defaults done");
      repeat (200) @(posedge i_clk);
      acc(0, 16'h4410, 0);
      `CHK({er, rd}, {1'b0, flt(100, 0)})
      acc(0, 16'h4412, 0);
      `CHK({er, rd}, {1'b0, flt(100, 0)})
      $display("stability done");
      foreach (wt[n]) begin
         acc(1, wt[n][48:33], wt[n][32:1]);
         `CHK(er, wt[n][0])
         if (!wt[n][0]) dflt[(wt[n][48:33] - 16'h6200) / 2] = wt[n][32:1];
         acc(0, wt[n][48:33], 0);
         `CHK({er, rd}, {1'b0, dflt[(wt[n][48:33] - 16'h6200) / 2]})
      end
      acc(1, 16'h4400, 32'h1);
      `CHK(er, 1'b1)
      acc(0, 16'h5000, 0);
      `CHK({er, rd}, {1'b1, 32'h0})
      $display("settings done");
      repeat (4) begin
         meas = '{12'($urandom), 12'($urandom), 12'($urandom), 12'($urandom), 12'($urandom),
            15'($urandom), 12'h100};
         ex = '{32'(meas.exc), 32'(meas.setting), 32'(meas.left), 32'(meas.right), 32'(meas.loop),
            32'(meas.cur_raw), flt(meas.cur_raw, 10), 32'(meas.loop) * 100 / 4095};
         // gain follows the loop value only once per stability pass, about 135 cycles at worst
         repeat (250) @(posedge i_clk);
         for (i = 0; i < 8; i++) begin
            acc(0, 16'h4400 + 16'(2 * i), 0);
            `CHK({er, rd}, {1'b0, ex[i]})
         end
      end
      $display("live values done");
      en = 1'b1;
      for (k = 1; k <= 5; k++) begin
         wait_edges(4 * k + 1);
         // a stability pass already running delays the sample by up to about 100 cycles
         repeat (160) @(posedge i_clk);
         sum = 0;
         for (i = 4 * k - 3; i <= 4 * k; i++) sum += (i <= 11) ? 200 : 300;
         raw = sum / 8;
         raws.push_back(raw);
         if (raws.size() > 2) void'(raws.pop_front());
         filt = raws.sum() / raws.size();
         acc(0, 16'h4200, 0);
         `CHK(near(rd, raw), 1'b1)
         acc(0, 16'h4202, 0);
         `CHK(near(rd, filt), 1'b1)
         acc(0, 16'h4204, 0);
         `CHK(near(rd, (raw > filt) ? raw - filt : filt - raw), 1'b1)
         acc(0, 16'h401c, 0);
         `CHK({er, rd}, {1'b0, (k >= 3) ? 32'h7000 : 32'h3000})
         if (k == 2) begin
            wait_edges(12);
            #1;
            half = 16'h0096;
         end
      end
      $display("period done");
      end_sim();
   end
endmodule

`default_nettype wire
